// ==== verilog/fgw_pkg.sv ====
// constants, field layouts and carrier types for the fast gpio block
// assumes a 32-bit axi4-lite master and at most eight ports of 32 pins
package fgw_pkg;
	localparam int PORT_W      = 32;
	localparam int ADDR_W      = 12;
	localparam int INT_PORTS   = 2;
	localparam int LEGACY_MAX  = 2;
	// address regions, taken from addr[11:8]
	localparam logic [3:0] REGION_PORT   = 4'h0;
	localparam logic [3:0] REGION_INT    = 4'h1;
	localparam logic [3:0] REGION_LEGACY = 4'h2;
	// per port offsets, port stride 0x20
	localparam logic [4:0] OFF_DIR  = 5'h00;
	localparam logic [4:0] OFF_OUT  = 5'h04;
	localparam logic [4:0] OFF_MASK = 5'h10;
	localparam logic [4:0] OFF_PIN  = 5'h14;
	localparam logic [4:0] OFF_SET  = 5'h18;
	localparam logic [4:0] OFF_CLR  = 5'h1c;
	// per interrupt port offsets, stride 0x20
	localparam logic [4:0] OFF_STAT_R = 5'h00;
	localparam logic [4:0] OFF_STAT_F = 5'h04;
	localparam logic [4:0] OFF_EN_R   = 5'h08;
	localparam logic [4:0] OFF_EN_F   = 5'h0c;
	localparam logic [4:0] OFF_CLR_R  = 5'h10;
	localparam logic [4:0] OFF_CLR_F  = 5'h14;
	localparam logic [2:0] INT_PORT_MAP [INT_PORTS] = '{3'h0, 3'h2};
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0]  STRB_ALL = 4'hf;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       valid;
		logic       isInt;
		logic       legacy;
		logic [2:0] idx;
		logic [4:0] off;
	} fgw_sel_t;

	typedef struct packed {
		logic [PORT_W-1:0] rise;
		logic [PORT_W-1:0] fall;
	} fgw_edge_t;

	// address decode; legacy window aliases the first ports
	function automatic fgw_sel_t fgw_dec(input logic [ADDR_W-1:0] a, input logic [3:0] nPorts);
		fgw_sel_t s;
		s.idx    = a[7:5];
		s.off    = a[4:0];
		s.isInt  = (a[11:8] == REGION_INT);
		s.legacy = (a[11:8] == REGION_LEGACY);
		s.valid  = ((a[11:8] == REGION_PORT) && ({1'b0, s.idx} < nPorts)) ||
		           (s.legacy && ({1'b0, s.idx} < 4'(LEGACY_MAX))) ||
		           (s.isInt && ({1'b0, s.idx} < 4'(INT_PORTS)));
		return s;
	endfunction
endpackage

// ==== verilog/fgw_gpio.sv ====
// fast gpio ports with masked, set and clear access and edge interrupts
// assumes an axi4-lite master on clk_sys; pins are asynchronous
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fgw_gpio #(
	parameter int NUM_PORTS = 5
) (
	// clock, reset, enable
	input  wire logic                                      clk_sys,
	input  wire logic                                      nrst,
	input  wire logic                                      ce,
	// axi4-lite slave
	input  wire logic [fgw_pkg::ADDR_W-1:0]                awaddr,
	input  wire logic                                      awvalid,
	output logic                                           awready,
	input  wire logic [31:0]                               wdata,
	input  wire logic [3:0]                                wstrb,
	input  wire logic                                      wvalid,
	output logic                                           wready,
	output logic [1:0]                                     bresp,
	output logic                                           bvalid,
	input  wire logic                                      bready,
	input  wire logic [fgw_pkg::ADDR_W-1:0]                araddr,
	input  wire logic                                      arvalid,
	output logic                                           arready,
	output logic [31:0]                                    rdata,
	output logic [1:0]                                     rresp,
	output logic                                           rvalid,
	input  wire logic                                      rready,
	// pins and peripheral claim
	input  wire logic [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] pinIn,
	output logic      [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] pinOut,
	output logic      [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] pinOe,
	input  wire logic [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] periphSel,
	input  wire logic [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] periphOut,
	input  wire logic [NUM_PORTS-1:0][fgw_pkg::PORT_W-1:0] periphOe,
	input  wire logic [fgw_pkg::INT_PORTS-1:0][fgw_pkg::PORT_W-1:0] analogSel,
	// interrupt and wake
	input  wire logic                                      extIrqLineThree,
	output logic                                           irq,
	output logic                                           wakeReq
);
	localparam logic [3:0] NP = 4'(NUM_PORTS);

	logic [NUM_PORTS-1:0][31:0] dirReg, maskReg, outReg, syncA, syncB;
	fgw_pkg::fgw_edge_t [fgw_pkg::INT_PORTS-1:0] statReg, enReg, edgeEv, clrVec;
	logic [fgw_pkg::INT_PORTS-1:0][31:0] prevReg;
	logic [fgw_pkg::ADDR_W-1:0] awAddrReg;
	logic [31:0]                wDataReg, byteMask, rdNext;
	logic [3:0]                 wStrbReg;
	logic                       doWr, rdHit;
	fgw_pkg::fgw_sel_t          wSel, rSel;

	// write fires once both address and data are held and no response waits
	assign doWr     = ce && !awready && !wready && !bvalid;
	assign wSel     = fgw_pkg::fgw_dec(awAddrReg, NP);
	assign rSel     = fgw_pkg::fgw_dec(araddr, NP);
	assign byteMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}}, {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};

	// write address and data channels, taken in either order
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			awAddrReg <= '0;
			wDataReg  <= fgw_pkg::RST_WORD;
			wStrbReg  <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				awready   <= 1'b0;
				awAddrReg <= awaddr;
			end
			if (wvalid && wready) begin
				wready   <= 1'b0;
				wDataReg <= wdata;
				wStrbReg <= wstrb;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp  <= fgw_pkg::RESP_OKAY;
		end else if (ce) begin
			if (doWr) begin
				bvalid <= 1'b1;
				bresp  <= wSel.valid ? fgw_pkg::RESP_OKAY : fgw_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// per port latches, direction, mask and pin drive
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		logic        hitP;
		logic [31:0] en;
		assign hitP = doWr && wSel.valid && !wSel.isInt && (wSel.idx == 3'(p));
		assign en   = byteMask & ~maskReg[p];

		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				dirReg[p]  <= fgw_pkg::RST_WORD;
				maskReg[p] <= fgw_pkg::RST_WORD;
				outReg[p]  <= fgw_pkg::RST_WORD;
			end else if (hitP) begin
				// legacy window lands here too, same storage
				unique case (wSel.off)
					fgw_pkg::OFF_DIR:  dirReg[p]  <= (dirReg[p] & ~byteMask) | (wDataReg & byteMask);
					fgw_pkg::OFF_MASK: maskReg[p] <= (maskReg[p] & ~byteMask) | (wDataReg & byteMask);
					fgw_pkg::OFF_PIN:  outReg[p]  <= (outReg[p] & ~en) | (wDataReg & en);
					fgw_pkg::OFF_SET:  outReg[p]  <= outReg[p] | (wDataReg & en);
					fgw_pkg::OFF_CLR:  outReg[p]  <= outReg[p] & ~(wDataReg & en);
					default: ;
				endcase
			end
		end

		// pins are asynchronous: two flops before anything looks at them
		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				syncA[p] <= '0;
				syncB[p] <= '0;
			end else begin
				syncA[p] <= pinIn[p];
				syncB[p] <= syncA[p];
			end
		end

		// peripheral claim wins; otherwise the port registers drive
		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				pinOut[p] <= '0;
				pinOe[p]  <= '0;
			end else if (ce) begin
				pinOut[p] <= (periphSel[p] & periphOut[p]) | (~periphSel[p] & outReg[p]);
				pinOe[p]  <= (periphSel[p] & periphOe[p]) | (~periphSel[p] & dirReg[p]);
			end
		end
	end

	// edge capture on the interrupt ports; kept running without ce so that
	// a frozen core still sees wake edges, as long as clk_sys itself runs
	for (genvar k = 0; k < fgw_pkg::INT_PORTS; k++) begin : g_int
		localparam int P = int'(fgw_pkg::INT_PORT_MAP[k]);
		logic hitK;
		assign hitK          = doWr && wSel.valid && wSel.isInt && (wSel.idx == 3'(k));
		assign edgeEv[k].rise = syncB[P] & ~prevReg[k] & enReg[k].rise & ~analogSel[k];
		assign edgeEv[k].fall = ~syncB[P] & prevReg[k] & enReg[k].fall & ~analogSel[k];
		assign clrVec[k].rise = (hitK && wSel.off == fgw_pkg::OFF_CLR_R) ? wDataReg & byteMask : '0;
		assign clrVec[k].fall = (hitK && wSel.off == fgw_pkg::OFF_CLR_F) ? wDataReg & byteMask : '0;

		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				prevReg[k] <= '0;
				statReg[k] <= '0;
			end else begin
				prevReg[k] <= syncB[P];
				// a new edge wins over a clear in the same cycle
				statReg[k] <= (statReg[k] & ~clrVec[k]) | edgeEv[k];
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				enReg[k] <= '0;
			end else if (hitK && wSel.off == fgw_pkg::OFF_EN_R) begin
				enReg[k].rise <= (enReg[k].rise & ~byteMask) | (wDataReg & byteMask);
			end else if (hitK && wSel.off == fgw_pkg::OFF_EN_F) begin
				enReg[k].fall <= (enReg[k].fall & ~byteMask) | (wDataReg & byteMask);
			end
		end
	end

	// level interrupt and wake; both stay live without ce
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irq     <= 1'b0;
			wakeReq <= 1'b0;
		end else begin
			irq     <= (|(statReg & enReg)) || extIrqLineThree;
			wakeReq <= |(statReg & enReg);
		end
	end

	// read mux; pin reads hide masked bits
	always_comb begin
		rdNext = fgw_pkg::RST_WORD;
		rdHit  = rSel.valid;
		if (rSel.valid && rSel.isInt) begin
			unique case (rSel.off)
				fgw_pkg::OFF_STAT_R: rdNext = statReg[rSel.idx[0]].rise;
				fgw_pkg::OFF_STAT_F: rdNext = statReg[rSel.idx[0]].fall;
				fgw_pkg::OFF_EN_R:   rdNext = enReg[rSel.idx[0]].rise;
				fgw_pkg::OFF_EN_F:   rdNext = enReg[rSel.idx[0]].fall;
				default:             rdNext = fgw_pkg::RST_WORD;
			endcase
		end else if (rSel.valid) begin
			unique case (rSel.off)
				fgw_pkg::OFF_DIR:  rdNext = dirReg[rSel.idx];
				fgw_pkg::OFF_OUT:  rdNext = outReg[rSel.idx];
				fgw_pkg::OFF_MASK: rdNext = maskReg[rSel.idx];
				fgw_pkg::OFF_PIN:  rdNext = syncB[rSel.idx] & ~maskReg[rSel.idx];
				default:           rdNext = fgw_pkg::RST_WORD;
			endcase
		end
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= fgw_pkg::RST_WORD;
			rresp   <= fgw_pkg::RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rdNext;
				rresp   <= rdHit ? fgw_pkg::RESP_OKAY : fgw_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// checks
	logic wrP0;
	assign wrP0 = doWr && wSel.valid && !wSel.isInt && (wSel.idx == 3'h0);

	drive_mux_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		ce |=> pinOe[0] == (($past(periphSel[0]) & $past(periphOe[0])) | (~$past(periphSel[0]) & $past(dirReg[0]))))
		else $error("pin enable not from claim or direction");
	dir_lane_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_DIR ##1 ce |=> pinOe[0] == dirReg[0] || $past(periphSel[0]) != '0)
		else $error("direction write not reaching pin enable");
	reset_input_a: assert property (@(posedge clk_sys)
		!nrst |=> pinOe == '0 && dirReg == '0)
		else $error("pins not inputs after reset");
	set_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_SET |=> outReg[0] == ($past(outReg[0]) | $past(wDataReg & g_port[0].en)))
		else $error("set write disturbed other bits");
	clr_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_CLR |=> outReg[0] == ($past(outReg[0]) & ~$past(wDataReg & g_port[0].en)))
		else $error("clear write disturbed other bits");
	latch_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		ce && arvalid && arready && rSel.valid && !rSel.isInt && rSel.idx == 3'h0 && rSel.off == fgw_pkg::OFF_OUT
		|=> rvalid && rdata == $past(outReg[0]))
		else $error("output latch readback wrong");
	mask_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_PIN |=> (outReg[0] & $past(maskReg[0])) == ($past(outReg[0]) & $past(maskReg[0])))
		else $error("masked bit changed on port write");
	lane_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_MASK |=> (maskReg[0] & ~$past(byteMask)) == ($past(maskReg[0]) & ~$past(byteMask)))
		else $error("unstrobed lane changed");
	full_word_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrP0 && wSel.off == fgw_pkg::OFF_PIN && wStrbReg == fgw_pkg::STRB_ALL && maskReg[0] == '0
		|=> outReg[0] == $past(wDataReg))
		else $error("full word write did not update port");
	edge_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		|edgeEv[1] |=> ($past(edgeEv[1]) & ~statReg[1]) == '0)
		else $error("qualified edge not flagged");
	frozen_cap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!ce && |edgeEv[1] |=> |statReg[1])
		else $error("edge lost while core frozen");
	wake_req_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		|edgeEv[1] ##1 1'b1 |=> wakeReq)
		else $error("enabled edge gave no wake");
	legacy_alias_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		doWr && wSel.valid && wSel.legacy && wSel.idx == 3'h0 && wSel.off == fgw_pkg::OFF_MASK &&
		wStrbReg == fgw_pkg::STRB_ALL |=> maskReg[0] == $past(wDataReg))
		else $error("legacy window not aliased");
	irq_merge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		extIrqLineThree || |(statReg & enReg) |=> irq) // irq, not wakeReq: wakeReq leaves out extIrqLineThree
		else $error("merged interrupt missing");
	sticky_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> ($past(statReg[1]) & ~$past(clrVec[1]) & ~statReg[1]) == '0)
		else $error("flag dropped without clear");

	set_write_c: cover property (@(posedge clk_sys) wrP0 && wSel.off == fgw_pkg::OFF_SET);
	edge_irq_c:  cover property (@(posedge clk_sys) |edgeEv[1] ##2 irq);
	legacy_c:    cover property (@(posedge clk_sys) doWr && wSel.legacy);
	clr_race_c:  cover property (@(posedge clk_sys) |(edgeEv[1] & clrVec[1]));
endmodule

// ==== sim/fgw_pin_model.sv ====
// pin model: resolves each pin from the block's drive and the outside
// assumes pinOe high means the block owns the pin
`timescale 1ns/1ps
module fgw_pin_model #(
	parameter int NP = 3
) (
	// block side
	input  wire logic [NP-1:0][31:0] pinOut,
	input  wire logic [NP-1:0][31:0] pinOe,
	// outside source and resolved level
	input  wire logic [NP-1:0][31:0] extLevel,
	output logic      [NP-1:0][31:0] pinIn
);
	// owned pins echo the block's drive on pinOut, free pins follow the outside source
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ==== sim/test_fast_gpio_with_edge_wake.sv ====
// self-checking bench for the fast gpio block
// assumes fgw_pkg is compiled first; three ports, irq ports 0 and 2
`timescale 1ns/1ps
module test_fast_gpio_with_edge_wake;
	localparam int NP = 3;
	typedef struct packed {
		logic [11:0] wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [11:0] ra;
		logic [31:0] exp;
	} fgw_row_t;
	logic                clk_sys = 0;
	logic                nrst = 0;
	logic                ce = 1;
	logic [11:0]         awaddr = 0;
	logic [11:0]         araddr = 0;
	logic [31:0]         wdata = 0;
	logic [3:0]          wstrb = 0;
	logic                awvalid = 0;
	logic                wvalid = 0;
	logic                bready = 0;
	logic                arvalid = 0;
	logic                rready = 0;
	logic                extIrqLineThree = 0;
	logic [1:0][31:0]    analogSel = '0;
	logic [NP-1:0][31:0] extLevel = '0;
	logic [NP-1:0][31:0] periphSel = '0;
	logic [NP-1:0][31:0] periphOut = '0;
	logic [NP-1:0][31:0] periphOe = '0;
	logic [NP-1:0][31:0] pinIn;
	logic [NP-1:0][31:0] pinOut;
	logic [NP-1:0][31:0] pinOe;
	logic                awready, wready, bvalid, arready, rvalid, irq, wakeReq;
	logic [1:0]          bresp, rresp, rs;
	logic [31:0]         rdata, rd;
	int                  miscompares = 0;
	int                  checked = 0;
	int                  cyc = 0;
	// write on port 0, where the port checks watch, then read back its direction, output latch or pin register
	fgw_row_t rows [10] = '{
		'{12'h000, 32'hffff_ffff, 4'hf, 12'h000, 32'hffff_ffff},
		'{12'h014, 32'h1234_5678, 4'hf, 12'h004, 32'h1234_5678},
		'{12'h018, 32'h0000_ff00, 4'hf, 12'h004, 32'h1234_ff78},
		'{12'h01c, 32'h0000_0078, 4'hf, 12'h004, 32'h1234_ff00},
		'{12'h014, 32'haaaa_aaaa, 4'h2, 12'h004, 32'h1234_aa00},
		'{12'h010, 32'h0000_ffff, 4'hf, 12'h014, 32'h1234_0000},
		'{12'h014, 32'h0000_0000, 4'hf, 12'h004, 32'h0000_aa00},
		'{12'h218, 32'h0001_0001, 4'hf, 12'h004, 32'h0001_aa00},
		'{12'h210, 32'h0000_0000, 4'hf, 12'h204, 32'h0001_aa00},
		'{12'h01c, 32'hffff_0000, 4'hc, 12'h014, 32'h0000_aa00}
	};

	fgw_gpio #(.NUM_PORTS(NP)) u_fgw_gpio (
		.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.periphSel(periphSel), .periphOut(periphOut), .periphOe(periphOe), .analogSel(analogSel),
		.extIrqLineThree(extIrqLineThree), .irq(irq), .wakeReq(wakeReq)
	);
	fgw_pin_model #(.NP(NP)) u_fgw_pin_model (
		.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn)
	);

	always #5 clk_sys = ~clk_sys;

	// a hang ends the run as a failure
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chkFlag(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// address and data offered together, each released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw = 0;
		logic w = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_sys);
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic stop_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		waitc(3);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			axw(rows[i].wa, rows[i].wd, rows[i].ws, rs);
			chk("write resp", fgw_pkg::RESP_OKAY, rs);
			waitc(4); // pins pass two synchroniser stages first
			axr(rows[i].ra, rd, rs);
			chk("row read", rows[i].exp, rd);
		end
		chk("drive enable", 32'hffff_ffff, pinOe[0]);
		chk("drive value", 32'h0000_aa00, pinOut[0]);
		// a claimed nibble takes the peripheral's drive, the rest stays with the port
		periphSel[0] <= 32'h0000_000f;
		periphOut[0] <= 32'h0000_0005;
		periphOe[0]  <= 32'h0000_0003;
		waitc(2);
		chk("claimed enable", 32'hffff_fff3, pinOe[0]);
		chk("claimed value", 32'h0000_aa05, pinOut[0]);
		// second reset in mid-run returns every pin to input
		periphSel[0] <= '0;
		nrst <= 1'b0;
		waitc(3);
		nrst <= 1'b1;
		waitc(1);
		chk("enable after reset", 32'h0, pinOe[0]);
		axr(12'h000, rd, rs);
		chk("dir after reset", 32'h0, rd);
		axr(12'h3f0, rd, rs);
		chk("unmapped read", {30'h0, fgw_pkg::RESP_SLVERR}, {30'h0, rs});
		axw(12'h060, 32'hffff_ffff, 4'hf, rs);
		chk("absent port", fgw_pkg::RESP_SLVERR, rs);
		// port 2 bit 3 enabled both ways, bit 4 left disabled
		axw(12'h128, 32'h8, 4'hf, rs);
		axw(12'h12c, 32'h8, 4'hf, rs);
		ce <= 1'b0;
		extLevel[2] <= 32'h18;
		waitc(5);
		chkFlag("irq frozen core", 1'b1, irq);
		chkFlag("wake", 1'b1, wakeReq);
		ce <= 1'b1;
		extLevel[2] <= 32'h0;
		waitc(5);
		axr(12'h120, rd, rs);
		chk("rise status", 32'h8, rd);
		axr(12'h124, rd, rs);
		chk("fall status", 32'h8, rd);
		axw(12'h130, 32'h8, 4'hf, rs);
		axw(12'h134, 32'h8, 4'hf, rs);
		waitc(2);
		axr(12'h120, rd, rs);
		chk("cleared status", 32'h0, rd);
		chkFlag("irq cleared", 1'b0, irq);
		// an analog pin gives no edge request
		analogSel[1] <= 32'h8;
		extLevel[2] <= 32'h8;
		waitc(5);
		chkFlag("irq analog", 1'b0, irq);
		extIrqLineThree <= 1'b1;
		waitc(2);
		chkFlag("irq line three", 1'b1, irq);
		chkFlag("wake line three", 1'b0, wakeReq);
		stop_test();
	end
endmodule
